// >>> logic/cssu_pkg.sv
// Purpose: Shared constants and types for the shift, sign-extend and sleep unit
// Assumes: Opcode bytes arrive whole from the instruction decoder
// Notes: Shift group second bytes are 8xH, the low nibble holds kind and operand mode
package cssu_pkg;

   // ****************************************
   // Encodings
   // ****************************************
   localparam logic [7:0] PREFIX_OP = 8'hCE;
   localparam logic [7:0] OP_SIGN_EXT = 8'hA8;
   localparam logic [7:0] OP_SLEEP = 8'hAF;
   localparam logic [3:0] SHIFT_GROUP = 4'h8;
   localparam logic [7:0] OP_ASR_PTR = 8'h8B;
   localparam logic [7:0] OP_LSR_PTR = 8'h8F;
   localparam int GROUP_MSB = 7;
   localparam int GROUP_LSB = 4;
   localparam int KIND_MSB = 3;
   localparam int KIND_LSB = 2;
   localparam int MODE_MSB = 1;
   localparam int MODE_LSB = 0;
   localparam int SIGN_BIT = 7;
   localparam int PRE_SIGN_BIT = 6;
   localparam int LSB_BIT = 0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam int ADDR_W = 24;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {SH_ASL, SH_LSL, SH_ASR, SH_LSR} cssu_kind_t;
   typedef enum logic [1:0] {MD_REG_A, MD_REG_B, MD_BASE, MD_PTR} cssu_mode_t;

   // ****************************************
   // Opcode field decode
   // ****************************************
   function automatic cssu_kind_t op_kind(input logic [7:0] op);
      op_kind = cssu_kind_t'(op[KIND_MSB:KIND_LSB]);
   endfunction

   function automatic cssu_mode_t op_mode(input logic [7:0] op);
      op_mode = cssu_mode_t'(op[MODE_MSB:MODE_LSB]);
   endfunction

   // Right shifts through the pointer pair are not part of this unit
   function automatic logic op_is_shift(input logic [7:0] op);
      op_is_shift = (op[GROUP_MSB:GROUP_LSB] == SHIFT_GROUP) &&
                    (op != OP_ASR_PTR) && (op != OP_LSR_PTR);
   endfunction

endpackage

// >>> logic/cssu_shift_if.sv
// Purpose: Carries an operand to the shifter and its result back
// Assumes: Purely combinational path, same clock domain
// Notes: ctrl side drives the request, unit side answers
`timescale 1ns/1ns
`default_nettype none
interface cssu_shift_if;
   cssu_pkg::cssu_kind_t kind;
   logic [7:0] operand;
   logic v_in;
   logic [7:0] result;
   logic n_out;
   logic v_out;
   logic c_out;
   logic z_out;
   modport ctrl (output kind, output operand, output v_in,
                 input result, input n_out, input v_out, input c_out, input z_out);
   modport unit (input kind, input operand, input v_in,
                 output result, output n_out, output v_out, output c_out, output z_out);
endinterface
`default_nettype wire

// >>> logic/cssu_shifter.sv
// Purpose: One-bit shifter with negative, overflow, carry and zero flags
// Assumes: Operand and kind are stable within the cycle
// Notes: Combinational; the caller registers result and flags
`timescale 1ns/1ns
`default_nettype none
module cssu_shifter (
   cssu_shift_if.unit sh
);

   // ****************************************
   // Shift and flag logic
   // ****************************************
   always_comb
   begin
      sh.result = cssu_pkg::BYTE_ZERO;
      sh.c_out = 1'b0;
      sh.v_out = sh.v_in;
      unique case (sh.kind)
         cssu_pkg::SH_ASL, cssu_pkg::SH_LSL:
         begin
            sh.result = {sh.operand[cssu_pkg::PRE_SIGN_BIT:cssu_pkg::LSB_BIT], 1'b0};
            sh.c_out = sh.operand[cssu_pkg::SIGN_BIT];
            // Overflow means the sign bit changed
            if (sh.kind == cssu_pkg::SH_ASL)
            begin
               sh.v_out = sh.operand[cssu_pkg::SIGN_BIT] ^
                          sh.operand[cssu_pkg::PRE_SIGN_BIT];
            end
         end
         cssu_pkg::SH_ASR:
         begin
            sh.result = {sh.operand[cssu_pkg::SIGN_BIT],
                         sh.operand[cssu_pkg::SIGN_BIT:1]};
            sh.c_out = sh.operand[cssu_pkg::LSB_BIT];
            sh.v_out = 1'b0;
         end
         cssu_pkg::SH_LSR:
         begin
            sh.result = {1'b0, sh.operand[cssu_pkg::SIGN_BIT:1]};
            sh.c_out = sh.operand[cssu_pkg::LSB_BIT];
         end
      endcase
      sh.n_out = sh.result[cssu_pkg::SIGN_BIT];
      sh.z_out = (sh.result == cssu_pkg::BYTE_ZERO);
   end

endmodule
`default_nettype wire

// >>> logic/cssu_top.sv
// Purpose: Executes sign extend, one-bit shifts and sleep entry for the CPU
// Assumes: Memory answers a read with mem_rd_valid; writes complete in one cycle
// Notes: Flags live here and are driven out; register writes are one-cycle strobes
// Functional notes
// - Sign extend copies accumulator bit 7
// - High register 00H or FFH, flags kept
// - Left shifts: bit 7 to carry, zero in
// - Arithmetic left also updates overflow flag
// - Logical left keeps overflow unchanged
// - Arithmetic left opcodes CEH 80H to 83H
// - Logical left opcodes CEH 84H to 87H
// - Base form address: base high, byte low
// - Large models take page from extended page
// - Arithmetic right clears overflow, updates others
// - Arithmetic right opcodes CEH 88H to 8AH
// - Logical right zero in, N cleared
// - Logical right opcodes CEH 8CH to 8EH
// - CEH AFH enters sleep, flags kept
// - Sleep halts processor, peripherals and oscillator
// - External interrupt wakes from sleep
`timescale 1ns/1ns
`default_nettype none
module cssu_top (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic instr_valid,
   input wire logic [7:0] prefix_byte,
   input wire logic [7:0] op_byte,
   input wire logic [7:0] low_addr_byte,
   output logic instr_ready,
   output logic instr_done,
   output logic illegal_op,
   input wire logic [7:0] acc_in,
   input wire logic [7:0] b_in,
   output logic a_wr_en,
   output logic [7:0] a_wr_data,
   output logic b_wr_en,
   output logic [7:0] b_wr_data,
   input wire logic [7:0] base_page_reg,
   input wire logic [15:0] pointer_pair,
   input wire logic [7:0] extended_page_reg,
   input wire logic large_memory_models,
   output logic [23:0] mem_addr,
   output logic mem_rd_en,
   input wire logic mem_rd_valid,
   input wire logic [7:0] mem_rd_data,
   output logic mem_wr_en,
   output logic [7:0] mem_wr_data,
   output logic flag_n,
   output logic flag_v,
   output logic flag_c,
   output logic flag_z,
   input wire logic ext_irq,
   output logic sleep_active
);

   // ****************************************
   // State
   // ****************************************
   typedef enum logic [1:0] {ST_IDLE, ST_MEM_WAIT, ST_SLEEP} cssu_state_t;

   typedef struct packed {
      cssu_state_t st;
      cssu_pkg::cssu_kind_t kind;
      logic [cssu_pkg::ADDR_W-1:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
      logic a_we;
      logic [7:0] a_data;
      logic b_we;
      logic [7:0] b_data;
      logic n;
      logic v;
      logic c;
      logic z;
      logic done;
      logic bad;
      logic irq_s1;
      logic irq_s2;
   } cssu_regs_t;

   cssu_regs_t r_r;
   cssu_regs_t r_nxt;

   cssu_shift_if sh ();

   cssu_shifter u_shifter (
      .sh(sh.unit)
   );

   logic take;
   cssu_pkg::cssu_mode_t mode;
   logic [7:0] page;

   // ****************************************
   // Decode helpers
   // ****************************************
   assign take = instr_valid && (r_r.st == ST_IDLE);
   assign mode = cssu_pkg::op_mode(op_byte);
   // Small memory models live in page zero
   assign page = large_memory_models ? extended_page_reg : cssu_pkg::BYTE_ZERO;

   // ****************************************
   // Shifter operand select
   // ****************************************
   always_comb
   begin
      sh.v_in = r_r.v;
      if (r_r.st == ST_MEM_WAIT)
      begin
         sh.kind = r_r.kind;
         sh.operand = mem_rd_data;
      end
      else
      begin
         sh.kind = cssu_pkg::op_kind(op_byte);
         sh.operand = (mode == cssu_pkg::MD_REG_B) ? b_in : acc_in;
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      r_nxt = r_r;
      r_nxt.rd = 1'b0;
      r_nxt.wr = 1'b0;
      r_nxt.a_we = 1'b0;
      r_nxt.b_we = 1'b0;
      r_nxt.done = 1'b0;
      r_nxt.bad = 1'b0;
      r_nxt.irq_s1 = ext_irq;
      r_nxt.irq_s2 = r_r.irq_s1;
      unique case (r_r.st)
         ST_IDLE:
         begin
            if (take)
            begin
               if (prefix_byte != cssu_pkg::PREFIX_OP)
               begin
                  r_nxt.bad = 1'b1;
                  r_nxt.done = 1'b1;
               end
               else if (op_byte == cssu_pkg::OP_SIGN_EXT)
               begin
                  // Flags are left alone
                  r_nxt.b_we = 1'b1;
                  r_nxt.b_data = acc_in[cssu_pkg::SIGN_BIT] ? cssu_pkg::BYTE_ONES
                                                            : cssu_pkg::BYTE_ZERO;
                  r_nxt.done = 1'b1;
               end
               else if (op_byte == cssu_pkg::OP_SLEEP)
               begin
                  r_nxt.st = ST_SLEEP;
                  r_nxt.done = 1'b1;
               end
               else if (cssu_pkg::op_is_shift(op_byte))
               begin
                  // Opcode bits pick kind and operand mode
                  r_nxt.kind = sh.kind;
                  if (mode == cssu_pkg::MD_REG_A || mode == cssu_pkg::MD_REG_B)
                  begin
                     r_nxt.a_we = (mode == cssu_pkg::MD_REG_A);
                     r_nxt.b_we = (mode == cssu_pkg::MD_REG_B);
                     r_nxt.a_data = sh.result;
                     r_nxt.b_data = sh.result;
                     r_nxt.n = sh.n_out;
                     r_nxt.v = sh.v_out;
                     r_nxt.c = sh.c_out;
                     r_nxt.z = sh.z_out;
                     r_nxt.done = 1'b1;
                  end
                  else
                  begin
                     if (mode == cssu_pkg::MD_BASE)
                     begin
                        r_nxt.addr = {page, base_page_reg, low_addr_byte};
                     end
                     else
                     begin
                        r_nxt.addr = {page, pointer_pair};
                     end
                     r_nxt.rd = 1'b1;
                     r_nxt.st = ST_MEM_WAIT;
                  end
               end
               else
               begin
                  r_nxt.bad = 1'b1;
                  r_nxt.done = 1'b1;
               end
            end
         end
         ST_MEM_WAIT:
         begin
            // Write back to the very address that was read
            if (mem_rd_valid)
            begin
               r_nxt.wr = 1'b1;
               r_nxt.wdata = sh.result;
               r_nxt.n = sh.n_out;
               r_nxt.v = sh.v_out;
               r_nxt.c = sh.c_out;
               r_nxt.z = sh.z_out;
               r_nxt.done = 1'b1;
               r_nxt.st = ST_IDLE;
            end
         end
         ST_SLEEP:
         begin
            // Only a synchronised interrupt level ends sleep
            if (r_r.irq_s2)
            begin
               r_nxt.st = ST_IDLE;
            end
         end
         // Unused state code falls back to idle rather than locking up
         default:
         begin
            r_nxt.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         r_r <= '0;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign instr_ready = (r_r.st == ST_IDLE);
   assign instr_done = r_r.done;
   assign illegal_op = r_r.bad;
   assign a_wr_en = r_r.a_we;
   assign a_wr_data = r_r.a_data;
   assign b_wr_en = r_r.b_we;
   assign b_wr_data = r_r.b_data;
   assign mem_addr = r_r.addr;
   assign mem_rd_en = r_r.rd;
   assign mem_wr_en = r_r.wr;
   assign mem_wr_data = r_r.wdata;
   assign flag_n = r_r.n;
   assign flag_v = r_r.v;
   assign flag_c = r_r.c;
   assign flag_z = r_r.z;
   // System uses this level to gate CPU, peripheral and oscillator clocks
   assign sleep_active = (r_r.st == ST_SLEEP);

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   logic ok_pre;
   assign ok_pre = take && (prefix_byte == cssu_pkg::PREFIX_OP);

   sequence seq_rmw_read;
      mem_rd_en ##1 mem_rd_valid;
   endsequence

   sequence seq_sleep_take;
      ok_pre && (op_byte == cssu_pkg::OP_SLEEP);
   endsequence

   AST_SIGNEXT_HIGH: assert property (
      ok_pre && op_byte == cssu_pkg::OP_SIGN_EXT |=>
      b_wr_en && b_wr_data == {8{$past(acc_in[cssu_pkg::SIGN_BIT])}})
      else $error("sign extend high byte wrong");

   AST_SIGNEXT_FLAGS: assert property (
      ok_pre && op_byte == cssu_pkg::OP_SIGN_EXT |=>
      $stable({flag_n, flag_v, flag_c, flag_z}) && !a_wr_en)
      else $error("sign extend touched flags");

   AST_SHL_A: assert property (
      ok_pre && (op_byte == 8'h80 || op_byte == 8'h84) |=>
      a_wr_en && flag_c == $past(acc_in[cssu_pkg::SIGN_BIT]) &&
      a_wr_data == {$past(acc_in[6:0]), 1'b0})
      else $error("left shift of A wrong");

   AST_ASL_V: assert property (
      ok_pre && op_byte == 8'h80 |=> flag_v == ($past(acc_in[7]) ^ $past(acc_in[6])))
      else $error("arithmetic left overflow wrong");

   AST_LSL_V: assert property (
      ok_pre && op_byte == 8'h85 |=> flag_v == $past(flag_v) && b_wr_en)
      else $error("logical left changed overflow");

   AST_ASR: assert property (
      ok_pre && op_byte == 8'h88 |=>
      !flag_v && a_wr_data[7] == $past(acc_in[7]) && flag_c == $past(acc_in[0]))
      else $error("arithmetic right wrong");

   AST_LSR_N: assert property (
      ok_pre && op_byte == 8'h8D |=> !flag_n && !b_wr_data[7] && flag_v == $past(flag_v))
      else $error("logical right flags wrong");

   AST_ZERO_FLAG: assert property (
      a_wr_en |-> flag_z == (a_wr_data == 8'h00) && flag_n == a_wr_data[7])
      else $error("zero or negative flag wrong");

   AST_BASE_ADDR: assert property (
      ok_pre && op_byte == 8'h82 |=>
      mem_rd_en && mem_addr[15:0] == {$past(base_page_reg), $past(low_addr_byte)})
      else $error("base relative address wrong");

   AST_PAGE: assert property (
      ok_pre && op_byte == 8'h87 |=> mem_rd_en &&
      mem_addr[23:16] == ($past(large_memory_models) ? $past(extended_page_reg) : 8'h00))
      else $error("page of memory operand wrong");

   AST_RMW: assert property (
      seq_rmw_read |=> mem_wr_en && $stable(mem_addr) && instr_done)
      else $error("read modify write did not write back");

   AST_SLEEP_ENTER: assert property (
      seq_sleep_take |=> sleep_active && $stable({flag_n, flag_v, flag_c, flag_z}))
      else $error("sleep entry wrong");

   AST_SLEEP_HALT: assert property (
      sleep_active |-> !instr_ready && !mem_rd_en && !mem_wr_en)
      else $error("activity while asleep");

   AST_WAKE: assert property (
      (sleep_active && ext_irq) [*3] |=> !sleep_active)
      else $error("interrupt did not wake");

endmodule
`default_nettype wire

// >>> bench/cssu_mem_model.sv
// Purpose: Data memory partner for the shift unit's read-modify-write cycles
// Assumes: One read outstanding; rd_lat adds wait cycles before read data
// Notes: Read data changes every cycle outside its valid cycle
`timescale 1ns/1ns
`default_nettype none
module cssu_mem_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [3:0] rd_lat,
   input wire logic [23:0] mem_addr,
   input wire logic mem_rd_en,
   input wire logic mem_wr_en,
   input wire logic [7:0] mem_wr_data,
   output logic mem_rd_valid,
   output logic [7:0] mem_rd_data
);
   logic [7:0] mem [0:255];
   logic [3:0] cnt_r;
   logic busy_r;
   logic [7:0] addr_r;
   // ****************************************
   // Memory behaviour
   // ****************************************
   // Plain always: the bench preloads cells directly
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
         addr_r <= 8'h00;
         mem_rd_valid <= 1'b0;
         mem_rd_data <= 8'h00;
      end
      else
      begin
         mem_rd_valid <= 1'b0;
         mem_rd_data <= ~mem_rd_data;
         if (mem_wr_en)
            mem[mem_addr[7:0]] <= mem_wr_data;
         if (mem_rd_en && rd_lat == 4'h0)
         begin
            mem_rd_valid <= 1'b1;
            mem_rd_data <= mem[mem_addr[7:0]];
         end
         else if (mem_rd_en)
         begin
            busy_r <= 1'b1;
            cnt_r <= rd_lat - 4'h1;
            addr_r <= mem_addr[7:0];
         end
         else if (busy_r && cnt_r == 4'h0)
         begin
            busy_r <= 1'b0;
            mem_rd_valid <= 1'b1;
            mem_rd_data <= mem[addr_r];
         end
         else if (busy_r)
            cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule
`default_nettype wire

// >>> bench/tb_cssu_top.sv
// Purpose: Self-checking bench for shifts, sign extend and sleep entry
// Assumes: Memory partner model on the data bus
// Notes: Flag expectations are tracked across instructions
`timescale 1ns/1ns
`default_nettype none
module tb_cssu_top;
   logic ref_clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0;
   logic [7:0] prefix_byte = 8'h00, op_byte = 8'h00, low_addr_byte = 8'h00;
   logic [7:0] acc_in = 8'h00, b_in = 8'h00, base_page_reg = 8'h3B;
   logic [7:0] extended_page_reg = 8'h07;
   logic [15:0] pointer_pair = 16'h12C3;
   logic large_memory_models = 1'b0, ext_irq = 1'b0;
   logic [3:0] rd_lat = 4'h0;
   logic instr_ready, instr_done, illegal_op, a_wr_en, b_wr_en, mem_rd_en, mem_wr_en;
   logic mem_rd_valid, flag_n, flag_v, flag_c, flag_z, sleep_active;
   logic [7:0] a_wr_data, b_wr_data, mem_rd_data, mem_wr_data;
   logic [23:0] mem_addr;
   logic n_m = 1'b0, v_m = 1'b0, c_m = 1'b0, z_m = 1'b0;
   logic [11:0] exp;
   logic [7:0] la;
   int bad_count = 0;
   int checks = 0;
   logic [7:0] rops [8] = '{8'h80, 8'h84, 8'h88, 8'h85, 8'h81, 8'h8C, 8'h89, 8'h8D};
   logic [7:0] rvals [8] = '{8'h90, 8'h3C, 8'hB9, 8'h01, 8'h80, 8'h6D, 8'h44, 8'hB9};
   logic [7:0] mops [6] = '{8'h82, 8'h86, 8'h8A, 8'h8E, 8'h83, 8'h87};
   logic [7:0] mvals [6] = '{8'hC0, 8'h40, 8'h81, 8'hB9, 8'h7F, 8'h00};
   logic [15:0] bad_ops [3] = '{16'hCE8B, 16'hCE8F, 16'h0080};

   always #25 ref_clk = ~ref_clk;

   cssu_top cssu_top_i (.ref_clk, .reset_n, .instr_valid, .prefix_byte, .op_byte,
      .low_addr_byte, .instr_ready, .instr_done, .illegal_op, .acc_in, .b_in, .a_wr_en,
      .a_wr_data, .b_wr_en, .b_wr_data, .base_page_reg, .pointer_pair, .extended_page_reg,
      .large_memory_models, .mem_addr, .mem_rd_en, .mem_rd_valid, .mem_rd_data, .mem_wr_en,
      .mem_wr_data, .flag_n, .flag_v, .flag_c, .flag_z, .ext_irq, .sleep_active);

   cssu_mem_model mem_i (.ref_clk, .reset_n, .rd_lat, .mem_addr, .mem_rd_en, .mem_wr_en,
      .mem_wr_data, .mem_rd_valid, .mem_rd_data);

   // ****************************************
   // Checking tasks
   // ****************************************
   task automatic close_out();
      if (bad_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk_val(input string nm, input logic [23:0] e, input logic [23:0] g);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_flags();
      chk_bit("flag_n", n_m, flag_n);
      chk_bit("flag_v", v_m, flag_v);
      chk_bit("flag_c", c_m, flag_c);
      chk_bit("flag_z", z_m, flag_z);
   endtask

   // Issue one instruction and wait, bounded, for its done pulse
   task automatic run(input logic [7:0] p, input logic [7:0] o, input logic [7:0] l);
      int n;
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      prefix_byte <= p;
      op_byte <= o;
      low_addr_byte <= l;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      n = 0;
      #1;
      while (instr_done !== 1'b1 && n < 20)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk_bit("instr_done", 1'b1, instr_done);
   endtask

   // Result byte, then N V C Z, for shift kind k
   function automatic logic [11:0] ref_sh(input logic [7:0] o, input logic [1:0] k,
                                          input logic v);
      logic [7:0] r;
      logic c;
      logic nv;
      nv = v;
      c = o[0];
      case (k)
         2'd0: {c, r, nv} = {o, 1'b0, o[7] ^ o[6]};
         2'd1: {c, r} = {o, 1'b0};
         2'd2: {r, nv} = {o[7], o[7:1], 1'b0};
         default: r = {1'b0, o[7:1]};
      endcase
      return {r, r[7], nv, c, r == 8'h00};
   endfunction

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge ref_clk);
         acc_in <= rvals[i];
         b_in <= rvals[i];
         run(8'hCE, rops[i], 8'h00);
         exp = ref_sh(rvals[i], rops[i][3:2], v_m);
         {n_m, v_m, c_m, z_m} = exp[3:0];
         chk_bit("a_wr_en", !rops[i][0], a_wr_en);
         chk_bit("b_wr_en", rops[i][0], b_wr_en);
         chk_val("wr_data", exp[11:4], rops[i][0] ? b_wr_data : a_wr_data);
         chk_flags();
      end
      for (int i = 0; i < 6; i++)
      begin
         @(posedge ref_clk);
         large_memory_models <= i[0];
         rd_lat <= 4'(i);
         la = mops[i][0] ? 8'hC3 : 8'hA4;
         mem_i.mem[la] = mvals[i];
         run(8'hCE, mops[i], 8'hA4);
         exp = ref_sh(mvals[i], mops[i][3:2], v_m);
         {n_m, v_m, c_m, z_m} = exp[3:0];
         chk_val("mem_addr", {i[0] ? 8'h07 : 8'h00, mops[i][0] ? 16'h12C3 : 16'h3BA4},
                 mem_addr);
         chk_bit("mem_wr_en", 1'b1, mem_wr_en);
         chk_val("mem_wr_data", exp[11:4], mem_wr_data);
         chk_flags();
         @(posedge ref_clk);
         #1;
         chk_val("mem_cell", exp[11:4], mem_i.mem[la]);
      end
      for (int i = 0; i < 2; i++)
      begin
         @(posedge ref_clk);
         acc_in <= i[0] ? 8'hA5 : 8'h7F;
         run(8'hCE, 8'hA8, 8'h00);
         chk_bit("b_wr_en", 1'b1, b_wr_en);
         chk_bit("a_wr_en", 1'b0, a_wr_en);
         chk_val("b_wr_data", i[0] ? 8'hFF : 8'h00, b_wr_data);
         chk_flags();
      end
      for (int i = 0; i < 3; i++)
      begin
         run(bad_ops[i][15:8], bad_ops[i][7:0], 8'h00);
         chk_bit("illegal_op", 1'b1, illegal_op);
         chk_bit("a_wr_en", 1'b0, a_wr_en);
         chk_flags();
      end
      run(8'hCE, 8'hAF, 8'h00);
      chk_bit("sleep_active", 1'b1, sleep_active);
      chk_flags();
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      op_byte <= 8'h80;
      for (int k = 0; k < 4; k++)
      begin
         @(posedge ref_clk);
         #1;
         chk_bit("instr_done", 1'b0, instr_done);
         chk_bit("instr_ready", 1'b0, instr_ready);
      end
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      ext_irq <= 1'b1;
      repeat (3) @(posedge ref_clk);
      ext_irq <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      chk_bit("sleep_active", 1'b0, sleep_active);
      chk_flags();
      @(posedge ref_clk);
      b_in <= 8'h01;
      run(8'hCE, 8'h81, 8'h00);
      chk_val("b_wr_data", 8'h02, b_wr_data);
      close_out();
   end

   // Whole run takes a little over a hundred cycles
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      bad_count++;
      close_out();
   end
endmodule
`default_nettype wire
